// *** rtl/adcsc_regs.svh ***
// Register offsets, field positions, reset values and timing counts
// Included by the converter status/control design files
`ifndef ADCSC_REGS_SVH
`define ADCSC_REGS_SVH

`define ADCSC_OFF_STATUS      12'h000
`define ADCSC_OFF_CTRL_FIRST  12'h004
`define ADCSC_OFF_RDATA       12'h04C
`define ADCSC_STATUS_RESET    32'h00000000
`define ADCSC_CTRL_RESET      32'h00000000
`define ADCSC_CTRL_MASK       32'h008FEB7F

`define ADCSC_ST_WDOG         0
`define ADCSC_ST_DONE         1
`define ADCSC_ST_START        4

`define ADCSC_CT_WCH_LO       0
`define ADCSC_CT_DONE_IE      5
`define ADCSC_CT_WDOG_IE      6
`define ADCSC_CT_SCAN         8
`define ADCSC_CT_WSINGLE      9
`define ADCSC_CT_DISC         11
`define ADCSC_CT_BURST_LO     13
`define ADCSC_CT_SYNC_LO      16
`define ADCSC_CT_RWDOG        23

`define ADCSC_CH_MAX          5'h11
`define ADCSC_CH_TEMP         5'h10
`define ADCSC_CH_VREF         5'h11

// Delays in converter clock cycles
`define ADCSC_FAST_DELAY      5'h07
`define ADCSC_SLOW_DELAY      5'h0E

`endif

// *** rtl/adcsc_pkg.sv ***
// Types shared by the converter status/control files
// Assumes adcsc_regs.svh is available on the include path
package adcsc_pkg;
    typedef enum logic [3:0] {
        ADCSC_SYNC_FREE     = 4'h0,
        ADCSC_SYNC_PARALLEL = 4'h6,
        ADCSC_SYNC_FAST     = 4'h7,
        ADCSC_SYNC_SLOW     = 4'h8
    } adcsc_sync_e;

    typedef enum logic [1:0] {
        ADCSC_SEQ_IDLE  = 2'b00,
        ADCSC_SEQ_FIRST = 2'b01,
        ADCSC_SEQ_AGAIN = 2'b11
    } adcsc_seq_e;
endpackage

// *** rtl/adcsc_sync_seq.sv ***
// Start sequencer for dual-converter synchronised modes
// Assumes one-cycle trigger pulses on the converter clock
`timescale 1ns/1ps
`include "adcsc_regs.svh"

module adcsc_sync_seq (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] sync_mode,
    input  wire logic       trigger,
    output logic            start_first,
    output logic            start_second
);
    adcsc_pkg::adcsc_seq_e state_r;
    logic [4:0]            count_r;
    logic [4:0]            delay;

    always_comb begin
        delay = (sync_mode == 4'(adcsc_pkg::ADCSC_SYNC_SLOW)) ?
                `ADCSC_SLOW_DELAY : `ADCSC_FAST_DELAY;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= adcsc_pkg::ADCSC_SEQ_IDLE;
            count_r      <= 5'h00;
            start_first  <= 1'b0;
            start_second <= 1'b0;
        end else begin
            start_first  <= 1'b0;
            start_second <= 1'b0;
            unique case (state_r)
                adcsc_pkg::ADCSC_SEQ_IDLE: begin
                    if (trigger) begin
                        unique case (sync_mode)
                            4'(adcsc_pkg::ADCSC_SYNC_PARALLEL): begin
                                start_first  <= 1'b1;
                                start_second <= 1'b1;
                            end
                            4'(adcsc_pkg::ADCSC_SYNC_FAST),
                            4'(adcsc_pkg::ADCSC_SYNC_SLOW): begin
                                start_second <= 1'b1;
                                count_r      <= 5'h01;
                                state_r      <= adcsc_pkg::ADCSC_SEQ_FIRST;
                            end
                            default: begin
                                // Free and reserved codes: own trigger only
                                start_first  <= 1'b1;
                            end
                        endcase
                    end
                end
                adcsc_pkg::ADCSC_SEQ_FIRST: begin
                    if (count_r == delay) begin
                        start_first <= 1'b1;
                        count_r     <= 5'h01;
                        if (sync_mode == 4'(adcsc_pkg::ADCSC_SYNC_SLOW))
                            state_r <= adcsc_pkg::ADCSC_SEQ_AGAIN;
                        else
                            state_r <= adcsc_pkg::ADCSC_SEQ_IDLE;
                    end else begin
                        count_r <= count_r + 5'h01;
                    end
                end
                adcsc_pkg::ADCSC_SEQ_AGAIN: begin
                    if (count_r == delay) begin
                        start_second <= 1'b1;
                        state_r      <= adcsc_pkg::ADCSC_SEQ_IDLE;
                    end else begin
                        count_r <= count_r + 5'h01;
                    end
                end
                default: state_r <= adcsc_pkg::ADCSC_SEQ_IDLE;
            endcase
        end
    end
endmodule // adcsc_sync_seq

// *** rtl/adcsc_wdog.sv ***
// Analog watchdog window compare and channel scoping
// Assumes result and channel arrive together with a valid pulse
`timescale 1ns/1ps

module adcsc_wdog (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        enable,
    input  wire logic        scan,
    input  wire logic        single,
    input  wire logic [4:0]  sel_chan,
    input  wire logic        res_valid,
    input  wire logic [4:0]  res_chan,
    input  wire logic [15:0] res_data,
    input  wire logic [15:0] low_thr,
    input  wire logic [15:0] high_thr,
    output logic             event_pulse
);
    logic in_scope;
    logic outside;

    always_comb begin
        // Without scan only one channel is converted, so select applies
        in_scope = (scan && !single) || (res_chan == sel_chan);
        outside  = (res_data < low_thr) || (res_data > high_thr);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            event_pulse <= 1'b0;
        else
            event_pulse <= enable && res_valid && in_scope && outside;
    end
endmodule // adcsc_wdog

// *** rtl/adcsc_top.sv ***
// Status and first control registers of one converter instance
// Assumes an APB master on pclk; conversion engine outside this block
//
// Summary of operation
// - Interrupt only from sequence done and watchdog event.
// - Start flag bit 4 set at sequence start; cleared by writing zero.
// - Done flag bit 1 set when routine sequence completes.
// - Done flag cleared by writing zero or reading the data register.
// - Watchdog flag bit 0 set on out-of-window result; write zero clears.
// - Control bit 23 enables watchdog on routine conversions.
// - Sync field 19:16: free, parallel, fast and slow follow-up codes.
// - Only the first instance acts on the sync field.
// - Discontinuous mode converts burst count plus one channels per trigger.
// - Control bit 11 enables discontinuous mode.
// - Bit 9 limits watchdog to selected channel while scanning.
// - Control bit 8 enables scan across the channel sequence.
// - Bits 6 and 5 gate watchdog and done interrupts.
// - Watchdog channel field 4:0 selects channels 0 to 17.
// - Channels 16, 17: sensor and reference on first, ground elsewhere.
// - Three instances; status at offset 0, first control at 4.
// - Parallel mode starts both together; data word packs second high.
// - Fast follow-up: second starts at trigger, first seven cycles later.
// - Slow follow-up: first after 14 cycles, second again 14 later.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "adcsc_regs.svh"

module adcsc_top #(
    parameter logic [1:0] INSTANCE = 2'd0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        trigger,
    input  wire logic        seq_start,
    input  wire logic        seq_done,
    input  wire logic        res_valid,
    input  wire logic [4:0]  res_chan,
    input  wire logic [15:0] res_data,
    input  wire logic [15:0] res_data_second,
    input  wire logic [15:0] watchdog_low_threshold,
    input  wire logic [15:0] watchdog_high_threshold,
    output logic             irq,
    output logic             start_first,
    output logic             start_second,
    output logic             scan_enable,
    output logic             discontinuous_enable,
    output logic [3:0]       burst_len,
    output logic [1:0]       ch16_route,
    output logic [1:0]       ch17_route
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_r;
    logic        wdog_flag_r;
    logic        done_flag_r;
    logic        start_flag_r;
    logic [31:0] rdata_r;
    logic        setup;
    logic        wr_status;
    logic        wr_ctrl;
    logic        rd_data;
    logic        mapped;
    logic        wdog_hit;
    logic [3:0]  sync_eff;
    logic [4:0]  wch;
    logic        trig_first;
    logic        trig_second;

    // Zero-wait slave: answers in the access cycle itself
    always_comb begin
        setup     = psel && !penable;
        mapped    = (paddr == `ADCSC_OFF_STATUS) ||
                    (paddr == `ADCSC_OFF_CTRL_FIRST) ||
                    (paddr == `ADCSC_OFF_RDATA);
        wr_status = psel && penable && pwrite &&
                    (paddr == `ADCSC_OFF_STATUS);
        wr_ctrl   = psel && penable && pwrite &&
                    (paddr == `ADCSC_OFF_CTRL_FIRST);
        rd_data   = psel && penable && !pwrite &&
                    (paddr == `ADCSC_OFF_RDATA);
        wch       = ctrl_r[`ADCSC_CT_WCH_LO +: 5];
        // Non-first instances ignore the sync field entirely
        sync_eff  = (INSTANCE == 2'd0) ?
                    ctrl_r[`ADCSC_CT_SYNC_LO +: 4] : 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register; reserved bits stay zero whatever is written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_r <= `ADCSC_CTRL_RESET;
        else if (wr_ctrl)
            ctrl_r <= pwdata & `ADCSC_CTRL_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags: write one keeps, write zero clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            start_flag_r <= 1'b0;
        else if (seq_start)
            start_flag_r <= 1'b1;
        else if (wr_status && !pwdata[`ADCSC_ST_START])
            start_flag_r <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            done_flag_r <= 1'b0;
        else if (seq_done)
            done_flag_r <= 1'b1;
        else if ((wr_status && !pwdata[`ADCSC_ST_DONE]) || rd_data)
            done_flag_r <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wdog_flag_r <= 1'b0;
        else if (wdog_hit)
            wdog_flag_r <= 1'b1;
        else if (wr_status && !pwdata[`ADCSC_ST_WDOG])
            wdog_flag_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Routine data latch, packs second converter in the high half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rdata_r <= 32'h00000000;
        else if (res_valid)
            // Reserved codes act as free mode, as in the sequencer
            rdata_r <= (sync_eff == 4'(adcsc_pkg::ADCSC_SYNC_PARALLEL) ||
                        sync_eff == 4'(adcsc_pkg::ADCSC_SYNC_FAST) ||
                        sync_eff == 4'(adcsc_pkg::ADCSC_SYNC_SLOW)) ?
                       {res_data_second, res_data} :
                       {16'h0000, res_data};
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read path, registered at setup so data is ready at access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                unique case (paddr)
                    `ADCSC_OFF_STATUS:
                        prdata <= {27'h0, start_flag_r, 2'b00,
                                   done_flag_r, wdog_flag_r};
                    `ADCSC_OFF_CTRL_FIRST: prdata <= ctrl_r;
                    `ADCSC_OFF_RDATA:      prdata <= rdata_r;
                    default:               prdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt from the two gated sources only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= (wdog_flag_r && ctrl_r[`ADCSC_CT_WDOG_IE]) ||
                   (done_flag_r && ctrl_r[`ADCSC_CT_DONE_IE]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode outputs to the conversion engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_enable          <= 1'b0;
            discontinuous_enable <= 1'b0;
            burst_len            <= 4'h1;
            ch16_route           <= 2'b00;
            ch17_route           <= 2'b00;
            start_first          <= 1'b0;
            start_second         <= 1'b0;
        end else begin
            scan_enable          <= ctrl_r[`ADCSC_CT_SCAN];
            discontinuous_enable <= ctrl_r[`ADCSC_CT_DISC];
            burst_len <= {1'b0, ctrl_r[`ADCSC_CT_BURST_LO +: 3]}
                         + 4'h1;
            // 0 ground, 1 temperature sensor, 2 internal reference
            ch16_route <= (INSTANCE == 2'd0) ? 2'b01 : 2'b00;
            ch17_route <= (INSTANCE == 2'd0) ? 2'b10 : 2'b00;
            start_first  <= trig_first;
            start_second <= trig_second;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    adcsc_wdog u_wdog (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (ctrl_r[`ADCSC_CT_RWDOG]),
        .scan        (ctrl_r[`ADCSC_CT_SCAN]),
        .single      (ctrl_r[`ADCSC_CT_WSINGLE]),
        .sel_chan    ((wch > `ADCSC_CH_MAX) ? 5'h1F : wch),
        .res_valid   (res_valid),
        .res_chan    (res_chan),
        .res_data    (res_data),
        .low_thr     (watchdog_low_threshold),
        .high_thr    (watchdog_high_threshold),
        .event_pulse (wdog_hit)
    );

    adcsc_sync_seq u_seq (
        .pclk         (pclk),
        .presetn      (presetn),
        .sync_mode    (sync_eff),
        .trigger      (trigger),
        .start_first  (trig_first),
        .start_second (trig_second)
    );
endmodule // adcsc_top

// *** tb/adcsc_monitor.sv ***
// Port-level checker for the converter status/control block
// Assumes zero-wait APB on pclk and bind to every adcsc_top instance
`timescale 1ns/1ps
`include "adcsc_regs.svh"
module adcsc_monitor #(
    parameter logic [1:0] INSTANCE = 2'd0
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        seq_done,
    input wire logic        res_valid,
    input wire logic        irq,
    input wire logic        start_second,
    input wire logic        scan_enable,
    input wire logic        discontinuous_enable,
    input wire logic [3:0]  burst_len,
    input wire logic [1:0]  ch16_route,
    input wire logic [1:0]  ch17_route
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] sh_r;
    logic [3:0]  src_r;
    logic        acc;
    logic        mapped;
    assign acc = psel && penable && pready;
    assign mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h04C;
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the control word and recent irq causes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_r <= 32'h0;
        end else if (acc && pwrite && paddr == 12'h004) begin
            sh_r <= pwdata & `ADCSC_CTRL_MASK;
        end
    end
    // Window of four covers the watchdog path, the longest cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_r <= 4'h0;
        end else begin
            src_r <= {src_r[2:0], seq_done | res_valid | (acc & pwrite)};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_ready_access: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    a_pready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped address");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped address");
    a_scan_shadow: assert property (scan_enable == $past(sh_r[8]))
        else $error("scan output differs from control bit");
    a_disc_shadow: assert property (
        discontinuous_enable == $past(sh_r[11]))
        else $error("discontinuous output differs from control bit");
    a_burst_shadow: assert property (
        burst_len == {1'b0, $past(sh_r[15:13])} + 4'h1)
        else $error("burst length not count plus one");
    a_irq_gated: assert property (
        !sh_r[5] && !sh_r[6] && !$past(sh_r[5]) && !$past(sh_r[6]) |-> !irq)
        else $error("irq while both enables clear");
    a_irq_cause: assert property ($rose(irq) |-> src_r != 4'h0)
        else $error("irq rose without a source event");
    a_second_gated: assert property (
        INSTANCE != 2'd0 |-> !start_second)
        else $error("sync start on a non-first instance");
    a_route_fixed: assert property ($past(presetn) |->
        ch16_route == (INSTANCE == 2'd0 ? 2'd1 : 2'd0) &&
        ch17_route == (INSTANCE == 2'd0 ? 2'd2 : 2'd0))
        else $error("channel 16/17 routing wrong");
    c_irq: cover property ($rose(irq));
    c_second: cover property (start_second);
    c_slverr: cover property (acc && pslverr);
endmodule // adcsc_monitor

bind adcsc_top adcsc_monitor #(.INSTANCE(INSTANCE)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .seq_done(seq_done), .res_valid(res_valid),
    .irq(irq), .start_second(start_second), .scan_enable(scan_enable),
    .discontinuous_enable(discontinuous_enable), .burst_len(burst_len),
    .ch16_route(ch16_route), .ch17_route(ch17_route)
);

// *** tb/adcsc_bench.sv ***
// Self-checking bench for the converter status/control block
// Assumes zero-wait APB slave; a second instance shares all inputs
`timescale 1ns/1ps
module adcsc_bench;
    logic        pclk, presetn, psel, penable, pwrite, trigger, err, hit;
    logic        seq_start, seq_done, res_valid, pready, pslverr, irq;
    logic        start_first, start_second, scan_enable, disc_en;
    logic        second_o;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  res_chan;
    logic [15:0] res_data, res_data_second, lo_thr, hi_thr;
    logic [3:0]  burst_len;
    logic [1:0]  ch16_route, ch17_route, ch16_o, ch17_o;
    int          num_errors, num_checks;

    adcsc_top #(.INSTANCE(2'd0)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trigger(trigger),
        .seq_start(seq_start), .seq_done(seq_done), .res_valid(res_valid),
        .res_chan(res_chan), .res_data(res_data),
        .res_data_second(res_data_second), .watchdog_low_threshold(lo_thr),
        .watchdog_high_threshold(hi_thr), .irq(irq),
        .start_first(start_first), .start_second(start_second),
        .scan_enable(scan_enable), .discontinuous_enable(disc_en),
        .burst_len(burst_len), .ch16_route(ch16_route),
        .ch17_route(ch17_route));
    // Second instance only shows whether sync and routing stay inert
    adcsc_top #(.INSTANCE(2'd1)) i_dut_other (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .trigger(trigger), .seq_start(seq_start),
        .seq_done(seq_done), .res_valid(res_valid), .res_chan(res_chan),
        .res_data(res_data), .res_data_second(res_data_second),
        .watchdog_low_threshold(lo_thr), .watchdog_high_threshold(hi_thr),
        .irq(), .start_first(), .start_second(second_o), .scan_enable(),
        .discontinuous_enable(), .burst_len(), .ch16_route(ch16_o),
        .ch17_route(ch17_o));

    always #20 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Optional start pulse lands on the access edge to race a clear
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        seq_start <= hit;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        seq_start <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            results();
        end
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        tick(1);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc(12'h000, 32'h0, "status");
        rdc(12'h004, 32'h0, "control");
        chk("burst", 32'h1, {28'h0, burst_len});
        chk("routes", 32'h6, {28'h0, ch16_route, ch17_route});
        chk("other routes", 32'h0, {28'h0, ch16_o, ch17_o});
        rdc(12'h010, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask
    task automatic t_ctrl();
        wr(12'h004, 32'hFFFFFFFF);
        rdc(12'h004, 32'h008FEB7F, "control mask");
        chk("scan", 32'h1, {31'h0, scan_enable});
        chk("disc", 32'h1, {31'h0, disc_en});
        for (int b = 0; b < 8; b++) begin
            wr(12'h004, {16'h0, 3'(b), 13'h0});
            chk("burst", 32'(b + 1), {28'h0, burst_len});
        end
        chk("scan off", 32'h0, {31'h0, scan_enable});
        $display("test control done");
    endtask
    task automatic t_flags();
        seq_start <= 1'b1;
        seq_done <= 1'b1;
        @(posedge pclk);
        seq_start <= 1'b0;
        seq_done <= 1'b0;
        @(posedge pclk);
        rdc(12'h000, 32'h12, "flags set");
        wr(12'h000, 32'h00000013);
        rdc(12'h000, 32'h12, "write one keeps");
        xfer(1'b0, 12'h04C, 32'h0);
        rdc(12'h000, 32'h10, "data read clears");
        hit = 1'b1;
        wr(12'h000, 32'h0);
        hit = 1'b0;
        rdc(12'h000, 32'h10, "set beats clear");
        wr(12'h000, 32'h0);
        rdc(12'h000, 32'h0, "write zero clears");
        wr(12'h004, 32'h20);
        seq_done <= 1'b1;
        @(posedge pclk);
        seq_done <= 1'b0;
        tick(3);
        chk("done irq", 32'h1, {31'h0, irq});
        wr(12'h000, 32'h0);
        chk("done irq clear", 32'h0, {31'h0, irq});
        $display("test flags done");
    endtask
    task automatic wd(input logic [31:0] c, input logic [4:0] ch,
                      input logic [15:0] v, input logic ex);
        wr(12'h004, c);
        wr(12'h000, 32'h0);
        res_valid <= 1'b1;
        res_chan <= ch;
        res_data <= v;
        @(posedge pclk);
        res_valid <= 1'b0;
        tick(4);
        chk("wdog irq", {31'h0, ex & c[6]}, {31'h0, irq});
        rdc(12'h000, {31'h0, ex}, "wdog flag");
    endtask
    task automatic t_wdog();
        wd(32'h00800043, 5'h03, 16'h012C, 1'b1);
        wd(32'h00800003, 5'h03, 16'h012C, 1'b1);
        wd(32'h00800043, 5'h03, 16'h0096, 1'b0);
        wd(32'h00800043, 5'h03, 16'h0032, 1'b1);
        wd(32'h00000043, 5'h03, 16'h012C, 1'b0);
        wd(32'h00800343, 5'h05, 16'h012C, 1'b0);
        wd(32'h00800143, 5'h05, 16'h012C, 1'b1);
        wd(32'h00800051, 5'h11, 16'h012C, 1'b1);
        wd(32'h00800052, 5'h12, 16'h012C, 1'b0);
        $display("test watchdog done");
    endtask
    task automatic t_sync();
        logic [3:0] md [5] = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h3};
        int         dl [5] = '{0, 0, 7, 14, 0};
        int         ns [5] = '{0, 1, 1, 2, 0};
        int         pf, ps, nf, n2, no;
        for (int i = 0; i < 5; i++) begin
            wr(12'h004, 32'h0);
            wr(12'h004, {12'h0, md[i], 16'h0});
            trigger <= 1'b1;
            @(posedge pclk);
            trigger <= 1'b0;
            pf = -1;
            ps = -1;
            nf = 0;
            n2 = 0;
            no = 0;
            for (int t = 0; t < 48; t++) begin
                @(posedge pclk);
                nf += int'(start_first === 1'b1);
                n2 += int'(start_second === 1'b1);
                no += int'(second_o === 1'b1);
                if (start_first === 1'b1) pf = t;
                if (start_second === 1'b1 && ps < 0) ps = t;
            end
            chk("first starts", 32'h1, 32'(nf));
            chk("second starts", 32'(ns[i]), 32'(n2));
            chk("other second", 32'h0, 32'(no));
            if (ns[i] > 0) chk("gap", 32'(dl[i]), 32'(pf - ps));
            res_valid <= 1'b1;
            res_data <= 16'h1234;
            res_data_second <= 16'hABCD;
            @(posedge pclk);
            res_valid <= 1'b0;
            tick(2);
            rdc(12'h04C, ns[i] > 0 ? 32'hABCD1234 : 32'h00001234,
                "data word");
        end
        $display("test sync done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, trigger, hit} = 7'h0;
        {seq_start, seq_done, res_valid, res_chan} = 8'h0;
        {paddr, pwdata, res_data, res_data_second} = 76'h0;
        lo_thr = 16'h0064;
        hi_thr = 16'h00C8;
        num_errors = 0;
        num_checks = 0;
        tick(2);
        presetn <= 1'b1;
        tick(1);
        t_reset();
        t_ctrl();
        t_flags();
        t_wdog();
        t_sync();
        results();
    end
endmodule // adcsc_bench
